// ==== dma_pair_chk.sv ====
// port assertions of the dma channel pair
`timescale 1ns/1ps
module dma_pair_chk
	import dma_pair_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        rx_item_waiting,
	input wire logic        tx_slot_free,
	input wire logic [1:0]  xfer_size,
	input wire logic        rx_ack,
	input wire logic        tx_ack,
	input wire logic        mem_req,
	input wire logic        mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0]  mem_size,
	input wire logic        mem_done
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_w_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_mem_end; mem_req && mem_done; endsequence
	property p_wr_answer; s_w_taken |-> ##[1:2] s_axi_bvalid; endproperty
	property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_req_cause; $rose(mem_req) |-> (mem_write ? $past(rx_item_waiting) : $past(tx_slot_free)); endproperty
	property p_size; $rose(mem_req) |-> mem_size == $past(xfer_size); endproperty
	property p_hold; mem_req && !mem_done |=> mem_req && $stable(mem_addr) && $stable(mem_write); endproperty
	property p_ack; s_mem_end |=> !mem_req && (rx_ack != tx_ack) && (rx_ack == $past(mem_write)); endproperty
	property p_gap; $fell(mem_req) |-> !mem_req [*2]; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	a_rd_answer: assert property (p_rd_answer) else $error("read data missing");
	a_r_stand: assert property (p_r_stand) else $error("read data dropped");
	a_req_cause: assert property (p_req_cause) else $error("transfer without request");
	a_size: assert property (p_size) else $error("transfer size wrong");
	a_hold: assert property (p_hold) else $error("transfer changed in flight");
	a_ack: assert property (p_ack) else $error("ack missing after done");
	a_gap: assert property (p_gap) else $error("transfers too close");
endmodule : dma_pair_chk

bind peripheral_dma_unit dma_pair_chk u_chk (.*);

// ==== dma_pair_params.svh ====
// offsets, field positions, reset values and sizes of the dma channel pair
`ifndef DMA_PAIR_PARAMS_SVH
`define DMA_PAIR_PARAMS_SVH

`define OFS_RX_CUR_PTR   12'h100
`define OFS_RX_CUR_CNT   12'h104
`define OFS_TX_CUR_PTR   12'h108
`define OFS_TX_CUR_CNT   12'h10c
`define OFS_RX_NXT_PTR   12'h110
`define OFS_RX_NXT_CNT   12'h114
`define OFS_TX_NXT_PTR   12'h118
`define OFS_TX_NXT_CNT   12'h11c
`define OFS_XFER_CTRL    12'h120
`define OFS_XFER_STAT    12'h124

`define ADDR_W           12
`define CNT_W            16

`define BIT_RX_EN        0
`define BIT_RX_DIS       1
`define BIT_TX_EN        8
`define BIT_TX_DIS       9

`define PTR_RESET        32'h0000_0000
`define CNT_RESET        16'h0000

`define SIZE_BYTE        2'h0
`define SIZE_HALF        2'h1
`define SIZE_WORD        2'h2

`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2

`endif

// ==== dma_pair_pkg.sv ====
// types of the dma channel pair
package dma_pair_pkg;

	// one direction's register set
	typedef struct packed {
		logic [31:0] cur_ptr;
		logic [15:0] cur_cnt;
		logic [31:0] nxt_ptr;
		logic [15:0] nxt_cnt;
	} chan_regs_t;

	// flags handed to the peripheral status
	typedef struct packed {
		logic done;
		logic all;
	} chan_flags_t;

	typedef enum logic [1:0] {
		XF_IDLE,
		XF_BUS,
		XF_WAIT
	} xfer_state_t;

endpackage : dma_pair_pkg

// ==== far_side_model.sv ====
// peripheral and memory responder beside the dma channel pair
`timescale 1ns/1ps
module far_side_model (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       rx_want,
	input wire logic       tx_want,
	input wire logic [3:0] lat,
	input wire logic       rx_ack,
	input wire logic       tx_ack,
	input wire logic       mem_req,
	output logic           rx_item_waiting,
	output logic           tx_slot_free,
	output logic           mem_done
);
	logic [3:0] cnt_q;
	// request drops for a cycle while the moved item is replaced
	always_ff @(posedge aclk) begin
		rx_item_waiting <= aresetn && rx_want && !rx_ack;
		tx_slot_free <= aresetn && tx_want && !tx_ack;
	end
	// memory raises mem_done lat+1 cycles after mem_req rises
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_done <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			mem_done <= 1'b0;
			if (mem_req && !mem_done) begin
				cnt_q <= (cnt_q >= lat) ? 4'h0 : cnt_q + 4'h1;
				mem_done <= (cnt_q >= lat);
			end
		end
	end
endmodule : far_side_model

// ==== peripheral_dma_unit.sv ====
// register interface and control of one rx/tx dma channel pair
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dma_pair_params.svh"


module peripheral_dma_unit
	import dma_pair_pkg::*;
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite slave
	input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [`ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// peripheral side
	input  wire logic                 rx_item_waiting,
	input  wire logic                 tx_slot_free,
	input  wire logic [1:0]           xfer_size,
	output logic                      rx_ack,
	output logic                      tx_ack,
	output chan_flags_t               rx_flags,
	output chan_flags_t               tx_flags,
	// system bus side
	output logic                      mem_req,
	output logic                      mem_write,
	output logic [31:0]               mem_addr,
	output logic [1:0]                mem_size,
	input  wire logic                 mem_done
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] step_of(input logic [1:0] sz);
		unique case (sz)
			`SIZE_BYTE: step_of = 32'h0000_0001;
			`SIZE_HALF: step_of = 32'h0000_0002;
			default:    step_of = 32'h0000_0004;
		endcase
	endfunction : step_of

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// ****************************************************************
	// axi4-lite write path
	// ****************************************************************
	logic [`ADDR_W-1:0] awaddr_q;
	logic               aw_have_q;
	logic [31:0]        wdata_q;
	logic [3:0]         wstrb_q;
	logic               w_have_q;
	logic               wr_fire;
	logic               wr_hit;

	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

	always_comb begin
		unique case (awaddr_q)
			`OFS_RX_CUR_PTR, `OFS_RX_CUR_CNT, `OFS_TX_CUR_PTR, `OFS_TX_CUR_CNT,
			`OFS_RX_NXT_PTR, `OFS_RX_NXT_CNT, `OFS_TX_NXT_PTR, `OFS_TX_NXT_CNT,
			`OFS_XFER_CTRL: wr_hit = 1'b1;
			default:        wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			awaddr_q      <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q     <= 1'b1;
			awaddr_q      <= {s_axi_awaddr[`ADDR_W-1:2], 2'b00};
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_have_q     <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q     <= 1'b0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q     <= 1'b1;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_have_q     <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// decoded write strobes
	logic wr_rcp, wr_rcc, wr_tcp, wr_tcc, wr_rnp, wr_rnc, wr_tnp, wr_tnc, wr_ctl;
	assign wr_rcp = wr_fire && awaddr_q == `OFS_RX_CUR_PTR;
	assign wr_rcc = wr_fire && awaddr_q == `OFS_RX_CUR_CNT;
	assign wr_tcp = wr_fire && awaddr_q == `OFS_TX_CUR_PTR;
	assign wr_tcc = wr_fire && awaddr_q == `OFS_TX_CUR_CNT;
	assign wr_rnp = wr_fire && awaddr_q == `OFS_RX_NXT_PTR;
	assign wr_rnc = wr_fire && awaddr_q == `OFS_RX_NXT_CNT;
	assign wr_tnp = wr_fire && awaddr_q == `OFS_TX_NXT_PTR;
	assign wr_tnc = wr_fire && awaddr_q == `OFS_TX_NXT_CNT;
	assign wr_ctl = wr_fire && awaddr_q == `OFS_XFER_CTRL;

	// ****************************************************************
	// enable status
	// ****************************************************************
	logic rx_en_q;
	logic tx_en_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_en_q <= 1'b0;
		end else if (wr_ctl && wstrb_q[0]) begin
			if (wdata_q[`BIT_RX_DIS]) begin
				rx_en_q <= 1'b0;
			end else if (wdata_q[`BIT_RX_EN]) begin
				rx_en_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_en_q <= 1'b0;
		end else if (wr_ctl && wstrb_q[1]) begin
			if (wdata_q[`BIT_TX_DIS]) begin
				tx_en_q <= 1'b0;
			end else if (wdata_q[`BIT_TX_EN]) begin
				tx_en_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// transfer engine
	// ****************************************************************
	xfer_state_t state_q;
	logic        dir_tx_q;
	chan_regs_t  rx_q;
	chan_regs_t  tx_q;
	logic        rx_go;
	logic        tx_go;
	logic        done_rx;
	logic        done_tx;

	assign rx_go   = rx_en_q && rx_item_waiting && rx_q.cur_cnt != `CNT_RESET;
	assign tx_go   = tx_en_q && tx_slot_free && tx_q.cur_cnt != `CNT_RESET;
	assign done_rx = state_q == XF_BUS && mem_done && !dir_tx_q;
	assign done_tx = state_q == XF_BUS && mem_done && dir_tx_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= XF_IDLE;
			dir_tx_q  <= 1'b0;
			mem_req   <= 1'b0;
			mem_write <= 1'b0;
			mem_addr  <= '0;
			mem_size  <= `SIZE_BYTE;
			rx_ack    <= 1'b0;
			tx_ack    <= 1'b0;
		end else begin
			rx_ack <= 1'b0;
			tx_ack <= 1'b0;
			unique case (state_q)
				XF_IDLE: begin
					// receive requests served before transmit
					if (rx_go || tx_go) begin
						state_q   <= XF_BUS;
						dir_tx_q  <= !rx_go;
						mem_req   <= 1'b1;
						mem_write <= rx_go;
						mem_addr  <= rx_go ? rx_q.cur_ptr : tx_q.cur_ptr;
						mem_size  <= xfer_size;
					end
				end
				XF_BUS: begin
					if (mem_done) begin
						mem_req <= 1'b0;
						rx_ack  <= !dir_tx_q;
						tx_ack  <= dir_tx_q;
						state_q <= XF_WAIT;
					end
				end
				XF_WAIT: begin
					// let the peripheral drop its request after the ack
					state_q <= XF_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// pointer and counter registers
	// ****************************************************************
	function automatic chan_regs_t chan_next(
		input chan_regs_t c, input logic done, input logic [31:0] step,
		input logic w_cp, input logic w_cc, input logic w_np, input logic w_nc,
		input logic [31:0] wd, input logic [3:0] st);
		chan_regs_t n;
		n = c;
		if (done) begin
			n.cur_ptr = c.cur_ptr + step;
			n.cur_cnt = c.cur_cnt - 16'h0001;
		end
		if (n.cur_cnt == `CNT_RESET && n.nxt_cnt != `CNT_RESET) begin
			n.cur_ptr = n.nxt_ptr;
			n.cur_cnt = n.nxt_cnt;
			n.nxt_cnt = `CNT_RESET;
		end
		if (w_cp) n.cur_ptr = merge(c.cur_ptr, wd, st);
		if (w_cc) n.cur_cnt = 16'(merge({16'h0000, c.cur_cnt}, wd, st));
		if (w_np) n.nxt_ptr = merge(c.nxt_ptr, wd, st);
		if (w_nc) n.nxt_cnt = 16'(merge({16'h0000, c.nxt_cnt}, wd, st));
		chan_next = n;
	endfunction : chan_next

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_q <= '{`PTR_RESET, `CNT_RESET, `PTR_RESET, `CNT_RESET};
		end else begin
			rx_q <= chan_next(rx_q, done_rx, step_of(mem_size), wr_rcp, wr_rcc, wr_rnp, wr_rnc, wdata_q, wstrb_q);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_q <= '{`PTR_RESET, `CNT_RESET, `PTR_RESET, `CNT_RESET};
		end else begin
			tx_q <= chan_next(tx_q, done_tx, step_of(mem_size), wr_tcp, wr_tcc, wr_tnp, wr_tnc, wdata_q, wstrb_q);
		end
	end

	// ****************************************************************
	// flags to peripheral
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_flags <= '0;
			tx_flags <= '0;
		end else begin
			// done flag set on reaching zero; set beats a simultaneous clear
			if (done_rx && rx_q.cur_cnt == 16'h0001) begin
				rx_flags.done <= 1'b1;
			end else if (wr_rcc || wr_rnc) begin
				rx_flags.done <= 1'b0;
			end
			if (done_tx && tx_q.cur_cnt == 16'h0001) begin
				tx_flags.done <= 1'b1;
			end else if (wr_tcc || wr_tnc) begin
				tx_flags.done <= 1'b0;
			end
			rx_flags.all <= rx_q.cur_cnt == `CNT_RESET && rx_q.nxt_cnt == `CNT_RESET;
			tx_flags.all <= tx_q.cur_cnt == `CNT_RESET && tx_q.nxt_cnt == `CNT_RESET;
		end
	end

	// ****************************************************************
	// axi4-lite read path
	// ****************************************************************
	logic [31:0] rd_val;
	logic        rd_hit;
	logic [`ADDR_W-1:0] ra;

	assign ra = {s_axi_araddr[`ADDR_W-1:2], 2'b00};

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (ra)
			`OFS_RX_CUR_PTR: rd_val = rx_q.cur_ptr;
			`OFS_RX_CUR_CNT: rd_val = {16'h0000, rx_q.cur_cnt};
			`OFS_TX_CUR_PTR: rd_val = tx_q.cur_ptr;
			`OFS_TX_CUR_CNT: rd_val = {16'h0000, tx_q.cur_cnt};
			`OFS_RX_NXT_PTR: rd_val = rx_q.nxt_ptr;
			`OFS_RX_NXT_CNT: rd_val = {16'h0000, rx_q.nxt_cnt};
			`OFS_TX_NXT_PTR: rd_val = tx_q.nxt_ptr;
			`OFS_TX_NXT_CNT: rd_val = {16'h0000, tx_q.nxt_cnt};
			`OFS_XFER_CTRL:  rd_val = 32'h0000_0000;
			`OFS_XFER_STAT: begin
				rd_val[`BIT_RX_EN] = rx_en_q;
				rd_val[`BIT_TX_EN] = tx_en_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule : peripheral_dma_unit

// ==== tb.sv ====
// self-checking bench of the dma channel pair
`timescale 1ns/1ps
`include "dma_pair_params.svh"
module tb
	import dma_pair_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_item_waiting, tx_slot_free;
	logic rx_ack, tx_ack, mem_req, mem_write, mem_done, rx_want, tx_want, rx_en, tx_en;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, first_a, last_a, rd_d;
	logic [3:0]  s_axi_wstrb, lat;
	logic [1:0]  s_axi_bresp, s_axi_rresp, xfer_size, mem_size;
	chan_flags_t rx_flags, tx_flags;
	int          miscompares, total_checks, seen, i;
	logic [9:0]  codes [10] = '{10'h001, 10'h000, 10'h003, 10'h001, 10'h002, 10'h100, 10'h000, 10'h300, 10'h101, 10'h202};
	peripheral_dma_unit DUT (.*);
	far_side_model u_far (.*);
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) if ((mem_req && mem_done) === 1'b1) begin
		if (seen == 0) first_a = mem_addr;
		last_a = mem_addr;
		seen++;
	end
	// ****************************************
	// checks, bus cycles
	// ****************************************
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task hang;
		miscompares++;
		$display("mismatch wait expected answer seen timeout");
		test_done();
	endtask : hang
	task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word
	task chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_resp
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = `AXI_OKAY, input logic lr = 1'b0);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !lr;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (n > 200) hang();
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			// late ready: answer seen first, taken one edge later
			if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1) s_axi_bready <= 1'b1;
		end while ((s_axi_bvalid && s_axi_bready) !== 1'b1);
		chk_resp("bresp", er, s_axi_bresp);
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, input logic [1:0] er = `AXI_OKAY, input logic lr = 1'b0);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !lr;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (n > 200) hang();
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
		end while ((s_axi_rvalid && s_axi_rready) !== 1'b1);
		rd_d = s_axi_rdata;
		chk_resp("rresp", er, s_axi_rresp);
		s_axi_rready <= 1'b0;
	endtask : rd
	task rdc(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk_word("rdata", e, rd_d);
	endtask : rdc
	// one buffer chain in one direction, disabled first, then enabled
	task run(input logic t, input logic [1:0] sz, input logic [15:0] nc, input logic [15:0] nn, input logic [3:0] l);
		logic [11:0] b;
		logic [31:0] st;
		int n;
		b = t ? `OFS_TX_CUR_PTR : `OFS_RX_CUR_PTR;
		st = (sz == `SIZE_BYTE) ? 32'h1 : (sz == `SIZE_HALF) ? 32'h2 : 32'h4;
		xfer_size <= sz;
		lat <= l;
		wr(b, 32'h1000);
		wr(b + 12'h4, {16'h0, nc});
		wr(b + 12'h10, 32'h2000);
		wr(b + 12'h14, {16'h0, nn});
		seen = 0;
		rx_want <= !t;
		tx_want <= t;
		repeat (10) @(posedge aclk);
		chk_word("idle", 32'h0, seen);
		wr(`OFS_XFER_CTRL, t ? 32'h100 : 32'h1);
		n = 0;
		while (seen < nc + nn) begin
			@(posedge aclk);
			n++;
			if (n > 1000) hang();
		end
		repeat (20) @(posedge aclk);
		chk_word("count", nc + nn, seen);
		chk_word("first", 32'h1000, first_a);
		chk_word("last", (nn != 0) ? 32'h2000 + (nn - 1) * st : 32'h1000 + (nc - 1) * st, last_a);
		rdc(b, (nn != 0) ? 32'h2000 + nn * st : 32'h1000 + nc * st);
		rdc(b + 12'h4, 32'h0);
		rdc(b + 12'h14, 32'h0);
		chk_word("flags", 32'h3, t ? tx_flags : rx_flags);
		wr(b + 12'h4, 32'h0);
		repeat (2) @(posedge aclk);
		chk_word("done", 32'h0, t ? tx_flags.done : rx_flags.done);
		rx_want <= 1'b0;
		tx_want <= 1'b0;
		wr(`OFS_XFER_CTRL, 32'h202);
	endtask : run
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_want, tx_want} = 8'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, lat, xfer_size} = 62'h0;
		s_axi_wstrb = 4'hf;
		{miscompares, total_checks, seen, rx_en, tx_en} = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 10; i++) rdc(12'h100 + 12'(i * 4), 32'h0);
		for (i = 0; i < 8; i++) begin
			wr(12'h100 + 12'(i * 4), 32'hdead_beef ^ i);
			rdc(12'h100 + 12'(i * 4), (32'hdead_beef ^ i) & (i[0] ? 32'h0000_ffff : 32'hffff_ffff));
		end
		rd(12'h128, `AXI_SLVERR);
		chk_word("unmapped", 32'h0, rd_d);
		// answers held while the ready comes late
		wr(`OFS_RX_NXT_PTR, 32'h1234_5678, `AXI_OKAY, 1'b1);
		rd(`OFS_RX_NXT_PTR, `AXI_OKAY, 1'b1);
		chk_word("late", 32'h1234_5678, rd_d);
		wr(`OFS_XFER_STAT, 32'h101, `AXI_SLVERR);
		rdc(`OFS_XFER_STAT, 32'h0);
		for (i = 0; i < 10; i++) begin
			if (codes[i][1]) rx_en = 1'b0;
			else if (codes[i][0]) rx_en = 1'b1;
			if (codes[i][9]) tx_en = 1'b0;
			else if (codes[i][8]) tx_en = 1'b1;
			wr(`OFS_XFER_CTRL, {22'h0, codes[i]});
			rdc(`OFS_XFER_STAT, {23'h0, tx_en, 7'h0, rx_en});
		end
		run(1'b0, `SIZE_WORD, 16'h2, 16'h1, 4'h0);
		run(1'b1, `SIZE_HALF, 16'h2, 16'h0, 4'h3);
		run(1'b0, `SIZE_BYTE, 16'h1, 16'h1, 4'h1);
		run(1'b1, 2'h3, 16'h1, 16'h2, 4'h2);
		test_done();
	end
endmodule : tb
